// file: rtl/tas_pkg.sv
package tas_pkg;
    localparam int          CLK_MHZ       = 100;
    localparam int          BLINK_MS      = 250;
    // Half period of the display blink, in clock cycles
    localparam int          BLINK_CYC     = BLINK_MS * 1000 * CLK_MHZ;
    localparam int          NSTACK        = 6;
    localparam logic [2:0]  STACK_LAST    = 3'h5;
    localparam int          AXI_AW        = 8;
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_LOCO      = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    localparam logic [7:0]  OFS_ADDR      = 8'h0C;
    localparam logic [7:0]  OFS_FUNC      = 8'h10;
    localparam int          CTRL_INIT_BIT = 4;
    localparam int          LOCO_FWD_BIT  = 8;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [3:0]  DIGIT_MAX     = 4'h9;
    localparam logic [13:0] W_THOUSAND    = 14'h3E8;
    localparam logic [13:0] W_HUNDRED     = 14'h064;
    localparam logic [13:0] W_TEN         = 14'h00A;
    localparam logic [13:0] SHORT_MAX     = 14'h063;
    localparam logic [15:0] MUL_14        = 16'h000F;
    localparam logic [15:0] MUL_28        = 16'h001D;

    typedef enum logic [2:0] {
        TAS_RUN  = 3'b001,
        TAS_MENU = 3'b010,
        TAS_EDIT = 3'b100
    } tas_state_e;

    typedef enum logic [1:0] {
        TAS_SS14  = 2'b00,
        TAS_SS28  = 2'b01,
        TAS_SS128 = 2'b10,
        TAS_FUNC  = 2'b11
    } tas_kind_e;

    localparam tas_kind_e   MODE_RST      = TAS_SS28;

    typedef struct packed {
        logic       scroll;
        logic       shift;
        logic       confirm;
        logic [4:0] fkey;
    } tas_keys_s;

    typedef struct packed {
        logic fwd;
        logic rev;
    } tas_dir_s;

    typedef struct packed {
        logic [15:0] digits;
        logic [3:0]  blank;
        logic        dot_up;
        logic        dot_dn;
        logic        dot_left;
        logic        dot_right;
        logic        dot_shift;
    } tas_disp_s;

    typedef struct packed {
        tas_kind_e   kind;
        logic        long_addr;
        logic [13:0] addr;
        logic        fwd;
        logic [6:0]  speed;
        logic [8:0]  func;
    } tas_cmd_s;
endpackage : tas_pkg

// file: rtl/tas_throttle.sv
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Stack holds six locomotive addresses for quick selection.
// [R2] Each entry stores any decimal address 0 to 9999.
// [R3] Factory initialisation loads entries with addresses 0 through 5.
// [R4] Scroll key steps to next entry, wrapping from last to first.
// [R5] New address overwrites the entry shown when the menu opened.
// [R6] Confirming the address menu starts editing the flashing ones digit.
// [R7] Knob clockwise increments the selected digit, counter-clockwise decrements.
// [R8] Digit keys 1 to 4 select digits freely; untouched digits keep values.
// [R9] Confirm key stores the four digits and selects that locomotive.
// [R10] Previous locomotive is left untouched when another address is selected.
// [R11] Short or long address form is chosen automatically.
// [R12] Centre dot flashes while switch disagrees with locomotive direction; the upper or lower dot flashes instead.
// [R13] With switch agreeing, knob movement takes over and sends speed.
// [R14] Switch centred: side dots show knob direction needed to match speed.
// [R15] Upper dot means forward needed, lower dot means backward needed.
// [R16] Nine function states kept and changes sent to the locomotive.
// [R17] Single press of keys 0 to 4 toggles that function.
// [R18] Shift then key 1 to 4 toggles functions 5 to 8.
// [R19] Knob digitised into 256 throttle positions.
// [R20] Modes 14, 28 and 128 steps each use their own command format.
// [R21] Switch centred stops the locomotive; knob does not change speed.
// [R22] Key 4 selects rightmost digit, key 1 leftmost.
// [R23] Shift makes the next key press take its alternate meaning.
// [R24] Edited digits saturate at 0 and 9.
module tas_throttle #(
    parameter int BLINK_CYCLES = tas_pkg::BLINK_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic [tas_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [tas_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire tas_pkg::tas_keys_s         keys,
    input  wire logic [7:0]                 knob,
    input  wire tas_pkg::tas_dir_s          dir_sw,
    output tas_pkg::tas_disp_s              disp,
    output tas_pkg::tas_cmd_s               cmd,
    output logic                            cmd_valid
);
    import tas_pkg::*;

    tas_state_e  state;
    logic [15:0] stack [NSTACK];                                    // [R1] [R2]
    logic [2:0]  ptr;
    logic [15:0] edit;
    logic [1:0]  sel;
    logic        shift_pend;
    logic        taken;
    logic        spd_pend;
    logic [8:0]  func;
    tas_kind_e   mode;
    logic [7:0]  loco_speed;
    logic        loco_fwd;
    logic [7:0]  knob_q;
    tas_dir_s    dir_q;
    logic        blink;
    logic [24:0] blink_cnt;
    logic [AXI_AW-1:0] aw_addr;
    logic [AXI_AW-1:0] wr_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        init_req;

    logic        in_run;
    logic        in_menu;
    logic        in_edit;
    logic        knob_moved;
    logic        knob_up;
    logic        knob_dn;
    logic        sw_centre;
    logic        sw_match;
    logic        dir_chg;
    logic        menu_key;
    logic [8:0]  tog;
    logic        func_evt;
    logic        send_spd;
    logic [3:0]  cur_digit;
    logic [13:0] addr_bin;

    ////////////////////////////////////////////////////////////////////////////////////
    assign in_run     = (state == TAS_RUN);
    assign in_menu    = (state == TAS_MENU);
    assign in_edit    = (state == TAS_EDIT);
    assign knob_up    = (knob > knob_q);
    assign knob_dn    = (knob < knob_q);
    assign knob_moved = knob_up | knob_dn;
    assign sw_centre  = !dir_sw.fwd && !dir_sw.rev;
    assign sw_match   = (dir_sw.fwd && loco_fwd) || (dir_sw.rev && !loco_fwd);
    assign dir_chg    = (dir_sw != dir_q);
    assign menu_key   = shift_pend && keys.fkey[0];
    assign cur_digit  = edit[{sel, 2'b00} +: 4];
    assign func_evt   = |tog;
    assign send_spd   = spd_pend && !func_evt;

    // Digit weights; the device picks the address form itself     [R11]
    assign addr_bin = 14'(stack[ptr][15:12]) * W_THOUSAND
                    + 14'(stack[ptr][11:8]) * W_HUNDRED
                    + 14'(stack[ptr][7:4]) * W_TEN
                    + 14'(stack[ptr][3:0]);

    always_comb begin
        tog = '0;
        if (in_run && !menu_key) begin
            if (shift_pend) begin
                tog[8:5] = keys.fkey[4:1];                          // [R18]
            end else begin
                tog[4:0] = keys.fkey;                               // [R17]
            end
        end
    end

    // 256 knob positions scaled to the step count of the mode     [R19] [R20]
    function automatic logic [6:0] tas_step(input tas_kind_e m, input logic [7:0] k);
        logic [15:0] p;
        p = '0;
        unique case (m)
            TAS_SS14:  p = 16'(k) * MUL_14;
            TAS_SS128: p = {1'b0, k, 7'h00};
            default:   p = 16'(k) * MUL_28;
        endcase
        return p[14:8];
    endfunction : tas_step

    ////////////////////////////////////////////////////////////////////////////////////
    // Menu and edit sequencing
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= TAS_RUN;
        end else begin
            unique case (state)
                TAS_RUN:  if (menu_key) state <= TAS_MENU;
                TAS_MENU: begin
                    if (keys.confirm) begin
                        state <= TAS_EDIT;                          // [R6]
                    end else if (keys.fkey[0]) begin
                        state <= TAS_RUN;
                    end
                end
                TAS_EDIT: if (keys.confirm) state <= TAS_RUN;       // [R9]
                default:  state <= TAS_RUN;
            endcase
        end
    end

    // Shift only arms the next key in normal running
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            shift_pend <= 1'b0;
        end else if (!in_run || menu_key) begin
            shift_pend <= 1'b0;
        end else if (keys.shift) begin
            shift_pend <= 1'b1;                                     // [R23]
        end else if (|keys.fkey || keys.scroll) begin
            shift_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ptr <= '0;
        end else if (init_req) begin
            ptr <= '0;
        end else if (in_run && keys.scroll && !shift_pend) begin
            ptr <= (ptr == STACK_LAST) ? 3'h0 : ptr + 3'h1;         // [R4]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NSTACK; i++) begin
                stack[i] <= 16'(i);                                 // [R3]
            end
        end else if (init_req) begin
            for (int i = 0; i < NSTACK; i++) begin
                stack[i] <= 16'(i);                                 // [R3]
            end
        end else if (in_edit && keys.confirm) begin
            stack[ptr] <= edit;                                     // [R5] [R9]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            edit <= '0;
            sel  <= '0;
        end else if (in_menu && keys.confirm) begin
            edit <= stack[ptr];
            sel  <= 2'h0;                                           // [R6]
        end else if (in_edit) begin
            if (keys.fkey[4]) begin
                sel <= 2'h0;                                        // [R8] [R22]
            end else if (keys.fkey[3]) begin
                sel <= 2'h1;                                        // [R8] [R22]
            end else if (keys.fkey[2]) begin
                sel <= 2'h2;                                        // [R8] [R22]
            end else if (keys.fkey[1]) begin
                sel <= 2'h3;                                        // [R8] [R22]
            end else if (knob_up && cur_digit < DIGIT_MAX) begin
                edit[{sel, 2'b00} +: 4] <= cur_digit + 4'h1;        // [R7] [R24]
            end else if (knob_dn && cur_digit != 4'h0) begin
                edit[{sel, 2'b00} +: 4] <= cur_digit - 4'h1;        // [R7] [R24]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Takeover and command generation
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            knob_q <= '0;
            dir_q  <= '0;
        end else begin
            knob_q <= knob;
            dir_q  <= dir_sw;
        end
    end

    // Selecting another address never commands the old one        [R10]
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            taken <= 1'b0;
        end else if (!in_run || keys.scroll || init_req) begin
            taken <= 1'b0;
        end else if (!taken && sw_match && knob_moved) begin
            taken <= 1'b1;                                          // [R13]
        end
    end

    // A speed update held back by a function command is sent next
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            spd_pend <= 1'b0;
        end else if (!in_run) begin
            spd_pend <= 1'b0;
        end else if ((!taken && sw_match && knob_moved)
                  || (taken && (dir_chg || (knob_moved && !sw_centre)))) begin
            spd_pend <= 1'b1;                                       // [R13]
        end else if (send_spd) begin
            spd_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            func <= '0;
        end else if (init_req) begin
            func <= '0;
        end else begin
            func <= func ^ tog;                                     // [R16]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cmd       <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= func_evt || send_spd;
            if (func_evt || send_spd) begin
                cmd.addr      <= addr_bin;
                cmd.long_addr <= (addr_bin > SHORT_MAX);            // [R11]
                cmd.func      <= func ^ tog;                        // [R16]
                cmd.fwd       <= dir_sw.fwd;
                cmd.speed     <= sw_centre ? 7'h00 : tas_step(mode, knob); // [R21]
                cmd.kind      <= func_evt ? TAS_FUNC : mode;        // [R20]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Display
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else if (blink_cnt >= 25'(BLINK_CYCLES - 1)) begin
            blink_cnt <= '0;
            blink     <= !blink;
        end else begin
            blink_cnt <= blink_cnt + 25'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            disp <= '0;
        end else begin
            disp.digits    <= in_edit ? edit : stack[ptr];
            disp.blank     <= (in_edit && blink) ? (4'h1 << sel) : 4'h0; // [R6]
            disp.dot_shift <= shift_pend;
            disp.dot_up    <= 1'b0;
            disp.dot_dn    <= 1'b0;
            disp.dot_left  <= 1'b0;
            disp.dot_right <= 1'b0;
            if (in_run && !taken) begin
                if (sw_centre) begin
                    disp.dot_left  <= (knob < loco_speed);          // [R14]
                    disp.dot_right <= (knob > loco_speed);          // [R14]
                end else begin
                    // Dot blanks on the off phase only while mismatched
                    disp.dot_up <= loco_fwd && (sw_match || blink);   // [R12] [R15]
                    disp.dot_dn <= !loco_fwd && (sw_match || blink);  // [R12] [R15]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; address and data are accepted in either order
    assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_addr  = aw_addr;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr == OFS_CTRL || wr_addr == OFS_LOCO
                              || wr_addr == OFS_STATUS || wr_addr == OFS_ADDR
                              || wr_addr == OFS_FUNC) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Software-written registers; init is a self-clearing strobe
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode       <= MODE_RST;
            loco_speed <= '0;
            loco_fwd   <= 1'b1;
            init_req   <= 1'b0;
        end else begin
            init_req <= 1'b0;
            if (do_write && wr_addr == OFS_CTRL && w_strb[0]) begin
                mode     <= tas_kind_e'(w_data[1:0] == 2'h3 ? MODE_RST : w_data[1:0]);
                init_req <= w_data[CTRL_INIT_BIT];                  // [R3]
            end
            if (do_write && wr_addr == OFS_LOCO) begin
                if (w_strb[0]) loco_speed <= w_data[7:0];
                if (w_strb[1]) loco_fwd <= w_data[LOCO_FWD_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_CTRL:   s_axi_rdata <= {30'h0, mode};
                OFS_LOCO:   s_axi_rdata <= {23'h0, loco_fwd, loco_speed};
                OFS_STATUS: s_axi_rdata <= {22'h0, shift_pend, taken, 1'b0, ptr, 1'b0, state};
                OFS_ADDR:   s_axi_rdata <= {2'h0, addr_bin, stack[ptr]};
                OFS_FUNC:   s_axi_rdata <= {23'h0, func};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    chk_scroll_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)   // [R4]
        in_run && keys.scroll && !shift_pend && !init_req && ptr == STACK_LAST
        |=> ptr == 3'h0) else $error("scroll did not wrap to first entry");

    chk_edit_start: assert property (@(posedge clk_sys) disable iff (!nrst)    // [R6]
        in_menu && keys.confirm |=> in_edit && sel == 2'h0 ##1 disp.digits == edit)
        else $error("edit did not start on ones digit");

    chk_digit_sat: assert property (@(posedge clk_sys) disable iff (!nrst)     // [R24]
        in_edit && knob_up && cur_digit == DIGIT_MAX && keys.fkey == '0 && !keys.confirm
        |=> cur_digit == DIGIT_MAX) else $error("digit passed nine");

    chk_confirm_store: assert property (@(posedge clk_sys) disable iff (!nrst) // [R9]
        in_edit && keys.confirm && !init_req
        |=> in_run && stack[$past(ptr)] == $past(edit)) else $error("address not stored");

    chk_func_toggle: assert property (@(posedge clk_sys) disable iff (!nrst)   // [R17]
        in_run && !shift_pend && keys.fkey[1] && !init_req
        |=> func[1] != $past(func[1]) ##0 cmd_valid && cmd.kind == TAS_FUNC)
        else $error("function key did not toggle");

    chk_shift_func: assert property (@(posedge clk_sys) disable iff (!nrst)    // [R18]
        in_run && shift_pend && keys.fkey[2] && !keys.fkey[0] && !init_req
        |=> func[6] != $past(func[6]) && func[2] == $past(func[2]))
        else $error("shifted key did not toggle upper function");

    chk_centre_stop: assert property (@(posedge clk_sys) disable iff (!nrst)   // [R21]
        cmd_valid && cmd.kind != TAS_FUNC && $past(sw_centre) |-> cmd.speed == 7'h00)
        else $error("speed sent with switch centred");

    chk_dot_dir: assert property (@(posedge clk_sys) disable iff (!nrst)       // [R15]
        in_run && !taken && !sw_centre && sw_match
        |=> disp.dot_up == $past(loco_fwd) && disp.dot_dn == !$past(loco_fwd))
        else $error("direction dot wrong");
endmodule : tas_throttle
`default_nettype wire

// file: dv/tas_station_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Command station stand-in: keeps the last command, counts function updates
module tas_station_model (
    input  wire logic              clk_sys,
    input  wire tas_pkg::tas_cmd_s cmd,
    input  wire logic              cmd_valid,
    output tas_pkg::tas_cmd_s      last_cmd,
    output int                     n_func
);
    import tas_pkg::*;
    initial n_func = 0;
    always @(posedge clk_sys) begin
        if (cmd_valid) begin
            last_cmd <= cmd;
            if (cmd.kind == TAS_FUNC) begin
                n_func <= n_func + 1;
            end
        end
    end
endmodule : tas_station_model
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tas_pkg::*;
    logic clk_sys = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, cmd_valid;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, knob = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [15:0] e;
    tas_keys_s keys = '0;
    tas_dir_s dir_sw = '0;
    tas_disp_s disp;
    tas_cmd_s cmd, last_cmd;
    int n_func, mismatches = 0, checks_done = 0, cycles = 0;
    tas_throttle #(.BLINK_CYCLES(4)) tas_throttle_inst (.clk_sys, .nrst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .keys, .knob, .dir_sw, .disp, .cmd, .cmd_valid);
    tas_station_model tas_station_model_inst (.clk_sys, .cmd, .cmd_valid, .last_cmd, .n_func);
    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // Sampling right after the edge sees the values held before that edge, the ones the design sampled on it
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk_sys);
        s_axi_awaddr <= a; s_axi_wdata <= v;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_awvalid | s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge clk_sys);
        rs = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk_sys);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge clk_sys);
        v = s_axi_rdata; rs = s_axi_rresp;
        s_axi_rready <= 0;
    endtask : rd
    task automatic press(input logic [7:0] k);
        @(posedge clk_sys);
        keys <= tas_keys_s'(k);
        @(posedge clk_sys);
        keys <= '0;
        repeat (3) @(posedge clk_sys);
    endtask : press
    task automatic turn(input int n, input logic [7:0] stp);
        repeat (n) begin
            @(posedge clk_sys);
            knob <= knob + stp;
            @(posedge clk_sys);
        end
        repeat (5) @(posedge clk_sys);
    endtask : turn
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1;
        rd(OFS_ADDR, d, r); chk("entry", d, 0);
        for (int i = 1; i <= 9; i++) begin
            press(8'h80);
            rd(OFS_ADDR, d, r); chk("entry", d, 32'((i % 6) * 32'h10001));
        end
        press(8'h40); press(8'h01); press(8'h20);
        rd(OFS_STATUS, d, r); chk("status", d & 32'h77, 32'h34);
        e = 0;
        repeat (8) begin
            @(posedge clk_sys);
            e = e | disp.blank;
        end
        chk("blank", e, 16'h1);
        turn(9, 8'h01); turn(3, 8'hFF); press(8'h08); turn(4, 8'h01);
        chk("digits", disp.digits, 16'h0046);
        press(8'h20);
        rd(OFS_ADDR, d, r); chk("entry", d, 32'h002E0046);
        press(8'h80);
        rd(OFS_ADDR, d, r); chk("entry", d, 32'h00040004);
        repeat (5) press(8'h80);
        $display("address entry test done");
        wr(OFS_LOCO, 32'h100, r);
        chk("bresp", r, RESP_OKAY);
        @(posedge clk_sys);
        dir_sw <= 2'b10;
        repeat (9) @(posedge clk_sys);
        chk("dot_up", disp.dot_up, 1);
        // Loco now backward against a forward switch: lower dot must flash
        wr(OFS_LOCO, 32'h0, r);
        d = 0;
        repeat (8) begin
            @(posedge clk_sys);
            d = {d[30:0], disp.dot_dn};
        end
        chk("dot_dn", d[7:0] != 8'hFF && d[7:0] != 8'h00, 1);
        wr(OFS_LOCO, 32'h100, r);
        for (int m = 0; m < 3; m++) begin
            wr(OFS_CTRL, m, r);
            turn(20, 8'h01);
            e = (m == 2) ? 16'(knob >> 1) : (16'(knob) * (m == 1 ? MUL_28 : MUL_14)) >> 8;
            chk("speed", last_cmd.speed, e[6:0]);
            chk("kind", last_cmd.kind, m);
            chk("addr", {last_cmd.long_addr, last_cmd.addr, last_cmd.fwd}, 93);
        end
        @(posedge clk_sys);
        dir_sw <= 2'b00;
        turn(3, 8'h01); chk("speed", last_cmd.speed, 0);
        press(8'h80); chk("dot_right", {disp.dot_right, disp.dot_left}, 2);
        $display("speed test done");
        for (int n = 0; n < 5; n++) press(8'(1 << n));
        for (int n = 1; n < 5; n++) begin
            press(8'h40);
            chk("dot_shift", disp.dot_shift, 1);
            press(8'(1 << n));
        end
        rd(OFS_FUNC, d, r); chk("func", d, 32'h1FF);
        chk("cmd_func", last_cmd.func, 9'h1FF);
        chk("func_cmds", n_func, 9);
        rd(8'h40, d, r); chk("rresp", r, RESP_SLVERR);
        chk("rdata", d, 32'h0);
        wr(8'h40, 32'h1, r); chk("bresp", r, RESP_SLVERR);
        wr(OFS_CTRL, 32'h11, r);
        rd(OFS_ADDR, d, r); chk("entry", d, 0);
        $display("function and register test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
